// ===== rtl/lih_regs.sv
// holding-register bank of the level indicator, modbus word access
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RULE1] version word returns version times 100, writes refused
// [RULE2] read-only identity word holds the model code; other codes mean variants
// [RULE3] status word two read-only, bits 4 and 10 reserved
// [RULE4] status bits 0..3: sensor, cable, underflow, overflow faults
// [RULE5] status bits 5..8: power-up inhibit of alarms 1..4
// [RULE6] status bit 9: temperature unit, 0 Celsius, 1 Fahrenheit
// [RULE7] status bits 11..14 mirror outputs 1..4 in order
// [RULE8] special command: 0 tare clear, 5 hold clear, 10 min/max clear, 15 tare
// [RULE9] point position accepts 0 to 4 fractional digits; here the word is read-only and holds reset value 0
// [RULE10] pin action 0..3; extended variant also accepts 4..6
// [RULE11] input offset accepted only between input low and high limits
// [RULE12] indication range: signed, unsigned or extended
// [RULE13] on input error analog output goes low if direction 0, high if 1
// [RULE14] alarm reference accepted only between lower bound and input high limit
// [RULE15] retransmit kind 0 is 4-20 mA, 1 is 0-20 mA
// [RULE16] every word is 16-bit signed two's complement
// [RULE17] addresses up to 12 read-only, above 12 read/write; here the special command word at 10 accepts writes
// [RULE18] serve function 03 reads and 06 single writes
// [RULE19] bad writes get an exception and leave the word unchanged
// [RULE20] reserved status bits read zero
module lih_regs #(
  parameter logic [15:0] FW_VERSION  = 16'h0064,
  parameter logic [15:0] MODEL_IDENT = 16'h005a  // arbitrary value
) (
  input  wire logic               mclk_i,            // 100 MHz clock
  input  wire logic               rst_b_i,           // async reset, low
  input  wire lih_pkg::lih_req_t  req_i,             // word request
  output logic                    rsp_valid_o,       // answer strobe
  output logic [7:0]              rsp_exc_o,         // exception code
  output logic [15:0]             rsp_data_o,        // read/echo data
  input  wire lih_pkg::lih_cond_t cond_i,            // indicator states
  input  wire logic               extended_variant_i,// extended model
  input  wire logic signed [15:0] input_low_limit_i, // offset lower
  input  wire logic signed [15:0] input_high_limit_i,// upper limit
  input  wire logic signed [15:0] lower_bound_limit_i,// ref lower
  output lih_pkg::lih_cmd_t       cmd_o,             // action pulses
  output lih_pkg::lih_cfg_t       cfg_o,             // config words
  output logic                    ao_err_force_o,    // override analog
  output logic                    ao_err_high_o      // 1 high, 0 low
);
  import lih_pkg::*;

  typedef struct packed {
    lih_cfg_t    cfg;
    lih_cmd_t    cmd;
    logic        rsp_valid;
    logic [7:0]  rsp_exc;
    logic [15:0] rsp_data;
    logic        ao_force;
    logic        ao_high;
  } lih_state_t;

  localparam lih_cfg_t CFG_RST = '{
    point_position:         LIH_RST_POINT_POS,
    key_action_select:      LIH_RST_KEY_ACTION,
    input_pin_action:       LIH_RST_PIN_ACTION,
    input_smoothing:        LIH_RST_SMOOTHING,
    input_offset:           LIH_RST_OFFSET,
    indication_range:       LIH_RST_IND_RANGE,
    root_extract_enable:    LIH_RST_ROOT_EXTRACT,
    analog_fault_direction: LIH_RST_FAULT_DIR,
    alarm_reference:        LIH_RST_ALARM_REF,
    retransmit_kind:        LIH_RST_RETRANSMIT
  };

  initial
  begin
    if (FW_VERSION[15])
    begin
      $error("FW_VERSION must be a positive signed word");
    end
  end

  // signed window check; words are two's complement
  function automatic logic in_window(input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
    in_window = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction

  lih_state_t s_q;
  lih_state_t s_d;
  logic [15:0] status_two;
  logic        input_error;

  always_comb
  begin
    status_two = 16'h0000;                                    // [RULE20]
    status_two[LIH_ST_SENSOR]    = cond_i.sensor_fault;       // [RULE4]
    status_two[LIH_ST_CABLE]     = cond_i.cable_fault;        // [RULE4]
    status_two[LIH_ST_UNDERFLOW] = cond_i.underflow;          // [RULE4]
    status_two[LIH_ST_OVERFLOW]  = cond_i.overflow;           // [RULE4]
    status_two[LIH_ST_INHIBIT+:4] = cond_i.inhibit;           // [RULE5]
    status_two[LIH_ST_UNIT]      = cond_i.unit_f;             // [RULE6]
    status_two[LIH_ST_OUTPUTS+:4] = cond_i.outputs;           // [RULE7]
  end

  assign input_error = cond_i.sensor_fault | cond_i.cable_fault
                     | cond_i.underflow | cond_i.overflow;

  always_comb
  begin
    logic        ok;
    logic [15:0] pin_max;
    logic [15:0] wd;
    ok      = 1'b0;
    pin_max = extended_variant_i ? LIH_PIN_ACTION_EXT
                                 : LIH_PIN_ACTION_STD;        // [RULE10]
    wd      = req_i.data;
    s_d           = s_q;
    s_d.cmd       = '0;
    s_d.rsp_valid = req_i.valid;
    s_d.rsp_exc   = LIH_EXC_NONE;
    s_d.rsp_data  = 16'h0000;
    // error force follows the input fault one clock later, not latched
    s_d.ao_force  = input_error;                              // [RULE13]
    s_d.ao_high   = s_q.cfg.analog_fault_direction[0];        // [RULE13]
    if (req_i.valid)
    begin
      unique case (req_i.func)
        LIH_FN_READ_HOLD:                                     // [RULE18]
        begin
          case (req_i.addr)
            LIH_ADDR_FW_VERSION:   s_d.rsp_data = FW_VERSION; // [RULE1]
            LIH_ADDR_MODEL_IDENT:  s_d.rsp_data = MODEL_IDENT;// [RULE2]
            LIH_ADDR_STATUS_TWO:   s_d.rsp_data = status_two; // [RULE3]
            // command word holds no value; reads return zero
            LIH_ADDR_SPECIAL_CMD:  s_d.rsp_data = 16'h0000;
            LIH_ADDR_POINT_POS:    s_d.rsp_data = s_q.cfg.point_position;
            LIH_ADDR_KEY_ACTION:   s_d.rsp_data = s_q.cfg.key_action_select;
            LIH_ADDR_PIN_ACTION:   s_d.rsp_data = s_q.cfg.input_pin_action;
            LIH_ADDR_SMOOTHING:    s_d.rsp_data = s_q.cfg.input_smoothing;
            LIH_ADDR_OFFSET:       s_d.rsp_data = s_q.cfg.input_offset;
            LIH_ADDR_IND_RANGE:    s_d.rsp_data = s_q.cfg.indication_range;
            LIH_ADDR_ROOT_EXTRACT:
              s_d.rsp_data = s_q.cfg.root_extract_enable;
            LIH_ADDR_FAULT_DIR:
              s_d.rsp_data = s_q.cfg.analog_fault_direction;
            LIH_ADDR_ALARM_REF:    s_d.rsp_data = s_q.cfg.alarm_reference;
            LIH_ADDR_RETRANSMIT:   s_d.rsp_data = s_q.cfg.retransmit_kind;
            default:               s_d.rsp_exc  = LIH_EXC_ADDRESS;
          endcase
        end
        LIH_FN_WRITE_SINGLE:                                  // [RULE18]
        begin
          s_d.rsp_data = wd;
          if (req_i.addr == LIH_ADDR_SPECIAL_CMD)
          begin
            // the one writable word at or below the read-only limit
            ok = 1'b1;
            unique case (wd)                                  // [RULE8]
              LIH_CMD_TARE_CLEAR:   s_d.cmd.tare_clear   = 1'b1;
              LIH_CMD_HOLD_CLEAR:   s_d.cmd.hold_clear   = 1'b1;
              LIH_CMD_MINMAX_CLEAR: s_d.cmd.minmax_clear = 1'b1;
              LIH_CMD_TARE_DO:      s_d.cmd.tare_do      = 1'b1;
              default:              ok = 1'b0;
            endcase
            if (!ok)
            begin
              s_d.rsp_exc = LIH_EXC_VALUE;                    // [RULE19]
            end
          end
          else if (req_i.addr <= LIH_ADDR_LAST_RO)            // [RULE17]
          begin
            s_d.rsp_exc = LIH_EXC_ADDRESS;                    // [RULE1] [RULE19]
          end
          else
          begin
            case (req_i.addr)
              LIH_ADDR_PIN_ACTION:
                ok = in_window(wd, 16'h0000, pin_max);        // [RULE10]
              LIH_ADDR_SMOOTHING:
                ok = in_window(wd, 16'h0000, LIH_SMOOTHING_MAX);
              LIH_ADDR_OFFSET:                                // [RULE11]
                ok = in_window(wd, input_low_limit_i, input_high_limit_i);
              LIH_ADDR_IND_RANGE:
                ok = in_window(wd, 16'h0000, LIH_IND_RANGE_MAX); // [RULE12]
              LIH_ADDR_ROOT_EXTRACT:
                ok = in_window(wd, 16'h0000, LIH_FLAG_MAX);
              LIH_ADDR_FAULT_DIR:
                ok = in_window(wd, 16'h0000, LIH_FLAG_MAX);   // [RULE13]
              LIH_ADDR_ALARM_REF:                             // [RULE14]
                ok = in_window(wd, lower_bound_limit_i, input_high_limit_i);
              LIH_ADDR_RETRANSMIT:
                ok = in_window(wd, 16'h0000, LIH_FLAG_MAX);   // [RULE15]
              default:
                ok = 1'b0;
            endcase
            if (!ok)
            begin
              s_d.rsp_exc = (req_i.addr > LIH_ADDR_RETRANSMIT)
                          ? LIH_EXC_ADDRESS : LIH_EXC_VALUE;  // [RULE19]
            end
            else
            begin
              // stored as the raw signed word
              case (req_i.addr)                               // [RULE16]
                LIH_ADDR_PIN_ACTION:   s_d.cfg.input_pin_action    = wd;
                LIH_ADDR_SMOOTHING:    s_d.cfg.input_smoothing     = wd;
                LIH_ADDR_OFFSET:       s_d.cfg.input_offset        = wd;
                LIH_ADDR_IND_RANGE:    s_d.cfg.indication_range    = wd;
                LIH_ADDR_ROOT_EXTRACT: s_d.cfg.root_extract_enable = wd;
                LIH_ADDR_FAULT_DIR:  s_d.cfg.analog_fault_direction = wd;
                LIH_ADDR_ALARM_REF:    s_d.cfg.alarm_reference     = wd;
                LIH_ADDR_RETRANSMIT:   s_d.cfg.retransmit_kind     = wd;
                default:               s_d.cfg = s_q.cfg;
              endcase
            end
          end
        end
        default:
        begin
          s_d.rsp_exc = LIH_EXC_FUNCTION;                     // [RULE18]
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_q <= '{cfg: CFG_RST, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // point position (0..4) and key action are read-only here: reset values
  assign rsp_valid_o    = s_q.rsp_valid;
  assign rsp_exc_o      = s_q.rsp_exc;
  assign rsp_data_o     = s_q.rsp_data;
  assign cmd_o          = s_q.cmd;
  assign cfg_o          = s_q.cfg;                            // [RULE9]
  assign ao_err_force_o = s_q.ao_force;
  assign ao_err_high_o  = s_q.ao_high;

endmodule
`default_nettype wire

// ===== include/lih_pkg.sv
// package for the level indicator holding-register bank
`default_nettype none
package lih_pkg;

  // word addresses of the holding registers
  localparam logic [15:0] LIH_ADDR_FW_VERSION   = 16'h0007;
  localparam logic [15:0] LIH_ADDR_MODEL_IDENT  = 16'h0008;
  localparam logic [15:0] LIH_ADDR_STATUS_TWO   = 16'h0009;
  localparam logic [15:0] LIH_ADDR_SPECIAL_CMD  = 16'h000a;
  localparam logic [15:0] LIH_ADDR_POINT_POS    = 16'h000b;
  localparam logic [15:0] LIH_ADDR_KEY_ACTION   = 16'h000c;
  localparam logic [15:0] LIH_ADDR_PIN_ACTION   = 16'h000d;
  localparam logic [15:0] LIH_ADDR_SMOOTHING    = 16'h000e;
  localparam logic [15:0] LIH_ADDR_OFFSET       = 16'h000f;
  localparam logic [15:0] LIH_ADDR_IND_RANGE    = 16'h0010;
  localparam logic [15:0] LIH_ADDR_ROOT_EXTRACT = 16'h0011;
  localparam logic [15:0] LIH_ADDR_FAULT_DIR    = 16'h0012;
  localparam logic [15:0] LIH_ADDR_ALARM_REF    = 16'h0013;
  localparam logic [15:0] LIH_ADDR_RETRANSMIT   = 16'h0014;
  // highest read-only address
  localparam logic [15:0] LIH_ADDR_LAST_RO      = 16'h000c;

  // modbus function and exception codes
  localparam logic [7:0]  LIH_FN_READ_HOLD      = 8'h03;
  localparam logic [7:0]  LIH_FN_WRITE_SINGLE   = 8'h06;
  localparam logic [7:0]  LIH_EXC_NONE          = 8'h00;
  localparam logic [7:0]  LIH_EXC_FUNCTION      = 8'h01;
  localparam logic [7:0]  LIH_EXC_ADDRESS       = 8'h02;
  localparam logic [7:0]  LIH_EXC_VALUE         = 8'h03;

  // special command values
  localparam logic [15:0] LIH_CMD_TARE_CLEAR    = 16'h0000;
  localparam logic [15:0] LIH_CMD_HOLD_CLEAR    = 16'h0005;
  localparam logic [15:0] LIH_CMD_MINMAX_CLEAR  = 16'h000a;
  localparam logic [15:0] LIH_CMD_TARE_DO       = 16'h000f;

  // value limits of the enumerated words
  localparam logic [15:0] LIH_POINT_POS_MAX     = 16'h0004;
  localparam logic [15:0] LIH_PIN_ACTION_STD    = 16'h0003;
  localparam logic [15:0] LIH_PIN_ACTION_EXT    = 16'h0006;
  localparam logic [15:0] LIH_SMOOTHING_MAX     = 16'h003c;
  localparam logic [15:0] LIH_IND_RANGE_MAX     = 16'h0002;
  localparam logic [15:0] LIH_FLAG_MAX          = 16'h0001;

  // indication range codes
  localparam logic [15:0] LIH_RANGE_SIGNED      = 16'h0000;
  localparam logic [15:0] LIH_RANGE_UNSIGNED    = 16'h0001;
  localparam logic [15:0] LIH_RANGE_EXTENDED    = 16'h0002;

  // reset values of the configuration words
  localparam logic [15:0] LIH_RST_POINT_POS     = 16'h0000;
  localparam logic [15:0] LIH_RST_KEY_ACTION    = 16'h0000;
  localparam logic [15:0] LIH_RST_PIN_ACTION    = 16'h0000;
  localparam logic [15:0] LIH_RST_SMOOTHING     = 16'h0000;
  localparam logic [15:0] LIH_RST_OFFSET        = 16'h0000;
  localparam logic [15:0] LIH_RST_IND_RANGE     = 16'h0000;
  localparam logic [15:0] LIH_RST_ROOT_EXTRACT  = 16'h0000;
  localparam logic [15:0] LIH_RST_FAULT_DIR     = 16'h0000;
  localparam logic [15:0] LIH_RST_ALARM_REF     = 16'h0000;
  localparam logic [15:0] LIH_RST_RETRANSMIT    = 16'h0000;

  // status word two bit positions
  localparam int LIH_ST_SENSOR    = 0;
  localparam int LIH_ST_CABLE     = 1;
  localparam int LIH_ST_UNDERFLOW = 2;
  localparam int LIH_ST_OVERFLOW  = 3;
  localparam int LIH_ST_INHIBIT   = 5;
  localparam int LIH_ST_UNIT      = 9;
  localparam int LIH_ST_OUTPUTS   = 11;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } lih_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  exc;
    logic [15:0] data;
  } lih_rsp_t;

  typedef struct packed {
    logic       sensor_fault;
    logic       cable_fault;
    logic       underflow;
    logic       overflow;
    logic [3:0] inhibit;
    logic       unit_f;
    logic [3:0] outputs;
  } lih_cond_t;

  typedef struct packed {
    logic tare_clear;
    logic hold_clear;
    logic minmax_clear;
    logic tare_do;
  } lih_cmd_t;

  typedef struct packed {
    logic [15:0] point_position;
    logic [15:0] key_action_select;
    logic [15:0] input_pin_action;
    logic [15:0] input_smoothing;
    logic [15:0] input_offset;
    logic [15:0] indication_range;
    logic [15:0] root_extract_enable;
    logic [15:0] analog_fault_direction;
    logic [15:0] alarm_reference;
    logic [15:0] retransmit_kind;
  } lih_cfg_t;

endpackage
`default_nettype wire

// ===== verification/lih_regs_sva.sv
// concurrent checks on the holding-register bank ports
`timescale 1ns/100ps
`default_nettype none
module lih_regs_sva
  import lih_pkg::*;
#(
  parameter logic [15:0] FW_VERSION = 16'h0064
) (
  input wire logic               mclk_i,              // clock
  input wire logic               rst_b_i,             // reset, low
  input wire lih_req_t           req_i,               // request
  input wire logic               rsp_valid_o,         // answer strobe
  input wire logic [7:0]         rsp_exc_o,           // exception
  input wire logic [15:0]        rsp_data_o,          // answer data
  input wire lih_cond_t          cond_i,              // states
  input wire logic               extended_variant_i,  // variant
  input wire logic signed [15:0] input_low_limit_i,   // low limit
  input wire logic signed [15:0] input_high_limit_i,  // high limit
  input wire logic signed [15:0] lower_bound_limit_i, // ref lower
  input wire lih_cmd_t           cmd_o,               // pulses
  input wire lih_cfg_t           cfg_o,               // config
  input wire logic               ao_err_force_o,      // analog force
  input wire logic               ao_err_high_o        // analog high
);
  logic rd;
  logic wr;
  logic flt;
  assign rd = req_i.valid && req_i.func == LIH_FN_READ_HOLD;
  assign wr = req_i.valid && req_i.func == LIH_FN_WRITE_SINGLE;
  assign flt = cond_i.sensor_fault || cond_i.cable_fault
               || cond_i.underflow || cond_i.overflow;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  function automatic logic [15:0] stat(lih_cond_t c);
    return {1'b0, c.outputs, 1'b0, c.unit_f, c.inhibit, 1'b0,
            c.overflow, c.underflow, c.cable_fault, c.sensor_fault};
  endfunction
  sequence s_rd(logic [15:0] a);
    rd && req_i.addr == a;
  endsequence
  sequence s_wr(logic [15:0] a, logic [15:0] d);
    wr && req_i.addr == a && req_i.data == d;
  endsequence
  sequence s_ok;
    rsp_valid_o && rsp_exc_o == LIH_EXC_NONE;
  endsequence
  property p_answer;
    req_i.valid |=> rsp_valid_o;
  endproperty
  property p_quiet;
    !req_i.valid |=> !rsp_valid_o && cmd_o == 4'h0;
  endproperty
  property p_func;
    req_i.valid && !rd && !wr |=> rsp_exc_o == LIH_EXC_FUNCTION;
  endproperty
  property p_ro_wr;
    wr && req_i.addr <= LIH_ADDR_LAST_RO
      && req_i.addr != LIH_ADDR_SPECIAL_CMD
      |=> rsp_exc_o == LIH_EXC_ADDRESS ##0 $stable(cfg_o);
  endproperty
  property p_fw;
    s_rd(LIH_ADDR_FW_VERSION) |=> s_ok ##0 rsp_data_o == FW_VERSION;
  endproperty
  property p_status;
    s_rd(LIH_ADDR_STATUS_TWO) |=> s_ok ##0
      rsp_data_o == stat($past(cond_i));
  endproperty
  property p_tare;
    s_wr(LIH_ADDR_SPECIAL_CMD, LIH_CMD_TARE_DO) |=> s_ok ##0 cmd_o == 4'h1;
  endproperty
  property p_dir;
    s_wr(LIH_ADDR_FAULT_DIR, 16'h0001) |=> s_ok ##1 ao_err_high_o;
  endproperty
  property p_force;
    flt |=> ao_err_force_o;
  endproperty
  property p_pin;
    s_wr(LIH_ADDR_PIN_ACTION, 16'h0006) ##0 !extended_variant_i
      |=> rsp_exc_o == LIH_EXC_VALUE;
  endproperty
  property p_keep;
    wr && req_i.addr == LIH_ADDR_RETRANSMIT && $signed(req_i.data) > 1
      |=> rsp_exc_o == LIH_EXC_VALUE ##0 $stable(cfg_o.retransmit_kind);
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_quiet: assert property (p_quiet) else $error("spurious answer");
  a_func: assert property (p_func) else $error("bad function kept");
  a_ro_wr: assert property (p_ro_wr) else $error("ro write taken");
  a_fw: assert property (p_fw) else $error("version word wrong");
  a_status: assert property (p_status) else $error("status wrong");
  a_tare: assert property (p_tare) else $error("tare pulse wrong");
  a_dir: assert property (p_dir) else $error("fault dir wrong");
  a_force: assert property (p_force) else $error("no analog force");
  a_pin: assert property (p_pin) else $error("pin action taken");
  a_keep: assert property (p_keep) else $error("bad value taken");
endmodule
bind lih_regs lih_regs_sva #(.FW_VERSION(FW_VERSION)) u_sva (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req_i),
  .rsp_valid_o(rsp_valid_o), .rsp_exc_o(rsp_exc_o), .rsp_data_o(rsp_data_o),
  .cond_i(cond_i), .extended_variant_i(extended_variant_i),
  .input_low_limit_i(input_low_limit_i),
  .input_high_limit_i(input_high_limit_i),
  .lower_bound_limit_i(lower_bound_limit_i), .cmd_o(cmd_o), .cfg_o(cfg_o),
  .ao_err_force_o(ao_err_force_o), .ao_err_high_o(ao_err_high_o));
`default_nettype wire

// ===== verification/lih_master.sv
// serial master model issuing single-word requests
`timescale 1ns/100ps
`default_nettype none
module lih_master
  import lih_pkg::*;
(
  input  wire logic     mclk_i, // clock
  output var lih_req_t  req_o   // request to bank
);
  lih_req_t pend[$];
  initial req_o = '0;
  task automatic put(input logic [7:0] f, input logic [15:0] a, d);
    pend.push_back('{1'b1, f, a, d});
  endtask
  // idle fields toggle so stale values never look like a request
  always @(posedge mclk_i)
  begin
    #1;
    if (pend.size() > 0)
      req_o = pend.pop_front();
    else
      req_o = '{1'b0, ~req_o.func, ~req_o.addr, ~req_o.data};
  end
endmodule
`default_nettype wire

// ===== verification/tb_level_indicator_holding_regs.sv
// self-checking bench for the holding-register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_level_indicator_holding_regs;
  import lih_pkg::*;
  typedef struct packed {
    logic [7:0] exc; logic [15:0] data; logic dchk; lih_cmd_t cmd;
  } lih_note_t;
  localparam logic [15:0] FW    = 16'h0064;
  localparam logic [15:0] MODEL = 16'h005a; // arbitrary value
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ext = 1'b0;
  logic rsp_valid, force_o, high_o;
  logic [7:0] rsp_exc;
  logic [15:0] rsp_data;
  lih_req_t req;
  lih_cond_t cond = '0;
  lih_cmd_t cmd;
  lih_cfg_t cfg;
  lih_note_t exp_q[$];
  lih_note_t n;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 33;
  logic [15:0] cv[4] = '{16'h0000, 16'h0005, 16'h000a, 16'h000f};
  logic [15:0] ro[5] = '{16'h0007, 16'h0008, 16'h0009, 16'h000b, 16'h000c};
  logic [15:0] gv[8] = '{16'h0003, 16'h003c, 16'h00c8, 16'h0002,
                         16'h0001, 16'h0001, 16'hffce, 16'h0001};
  // address, value, accepted
  logic [27:0] tab[20] = '{28'h0d00031, 28'h0d00040, 28'h0dffff0,
    28'h0d00060, 28'h0e003c1, 28'h0e003d0, 28'h0f00c81, 28'h0f00c90,
    28'h0fff9b0, 28'h1000021, 28'h1000030, 28'h1100011, 28'h1100020,
    28'h1200011, 28'h1200020, 28'h13ffce1, 28'h13ffcd0, 28'h1300c90,
    28'h1400011, 28'h1480000};
  always #5 mclk_i = ~mclk_i;
  lih_master m (.mclk_i(mclk_i), .req_o(req));
  lih_regs #(.FW_VERSION(FW), .MODEL_IDENT(MODEL)) DUT (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req), .rsp_valid_o(rsp_valid),
    .rsp_exc_o(rsp_exc), .rsp_data_o(rsp_data), .cond_i(cond),
    .extended_variant_i(ext), .input_low_limit_i(16'hff9c),
    .input_high_limit_i(16'h00c8), .lower_bound_limit_i(16'hffce),
    .cmd_o(cmd), .cfg_o(cfg), .ao_err_force_o(force_o),
    .ao_err_high_o(high_o));
  task automatic summarize;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rq(input logic [7:0] f, input logic [15:0] a, d,
                    input logic [7:0] e, input logic [15:0] ed,
                    input logic dc = 1'b1, input lih_cmd_t c = '0);
    exp_q.push_back('{e, ed, dc, c});
    m.put(f, a, d);
  endtask
  task automatic drain;
    while (exp_q.size() > 0)
      @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      summarize();
    end
    if (rsp_valid === 1'b1)
    begin
      n = exp_q.pop_front();
      `CHK("exc", n.exc, rsp_exc)
      `CHK("cmd", n.cmd, cmd)
      if (n.dchk)
        `CHK("data", n.data, rsp_data)
    end
  end
  initial
  begin
    repeat (16) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    for (int a = 6; a <= 21; a++)
      rq(LIH_FN_READ_HOLD, 16'(a), 16'h0000,
         (a < 7 || a > 20) ? LIH_EXC_ADDRESS : LIH_EXC_NONE,
         a == 7 ? FW : a == 8 ? MODEL : 16'h0000);
    rq(8'h04, 16'h0009, 16'h0000, LIH_EXC_FUNCTION, 16'h0000, 1'b0);
    drain();
    `CHK("cfg_reset", 160'h0, cfg)
    $display("test reset_map done");
    repeat (8)
    begin
      cond = 13'($random(seed));
      rq(LIH_FN_READ_HOLD, LIH_ADDR_STATUS_TWO, 16'h0000, LIH_EXC_NONE,
         {1'b0, cond.outputs, 1'b0, cond.unit_f, cond.inhibit, 1'b0,
          cond.overflow, cond.underflow, cond.cable_fault,
          cond.sensor_fault});
      drain();
    end
    $display("test status done");
    foreach (ro[i])
      rq(LIH_FN_WRITE_SINGLE, ro[i], 16'h0001, LIH_EXC_ADDRESS, 16'h0, 1'b0);
    rq(LIH_FN_READ_HOLD, LIH_ADDR_FW_VERSION, 16'h0, LIH_EXC_NONE, FW);
    foreach (cv[i])
      rq(LIH_FN_WRITE_SINGLE, LIH_ADDR_SPECIAL_CMD, cv[i], LIH_EXC_NONE,
         cv[i], 1'b1, lih_cmd_t'(4'h8 >> i));
    rq(LIH_FN_WRITE_SINGLE, LIH_ADDR_SPECIAL_CMD, 16'h0003, LIH_EXC_VALUE,
       16'h0, 1'b0);
    drain();
    $display("test ro_and_cmd done");
    foreach (tab[i])
      rq(LIH_FN_WRITE_SINGLE, {8'h00, tab[i][27:20]}, tab[i][19:4],
         tab[i][0] ? LIH_EXC_NONE : LIH_EXC_VALUE, tab[i][19:4],
         tab[i][0]);
    foreach (gv[i])
      rq(LIH_FN_READ_HOLD, 16'h000d + 16'(i), 16'h0, LIH_EXC_NONE, gv[i]);
    drain();
    ext = 1'b1;
    rq(LIH_FN_WRITE_SINGLE, 16'h000d, 16'h0006, LIH_EXC_NONE, 16'h0006);
    rq(LIH_FN_WRITE_SINGLE, 16'h000d, 16'h0007, LIH_EXC_VALUE, 16'h0, 1'b0);
    rq(LIH_FN_READ_HOLD, 16'h000d, 16'h0, LIH_EXC_NONE, 16'h0006);
    drain();
    $display("test ranges done");
    cond = '0;
    cond.cable_fault = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("force", 1'b1, force_o)
    `CHK("high", 1'b1, high_o)
    rq(LIH_FN_WRITE_SINGLE, LIH_ADDR_FAULT_DIR, 16'h0, LIH_EXC_NONE, 16'h0);
    drain();
    `CHK("low", 1'b0, high_o)
    $display("test fault_output done");
    summarize();
  end
endmodule
`default_nettype wire
